/* File: hdl/phase_shift_pkg.sv */
// Shared constants and types of the phase shift control port
package phase_shift_pkg;

    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam int PHASE_W = 6;
    localparam int BIT_CNT_W = 4;
    localparam int LATCH_CNT_W = 16;
    localparam int SYNC_W = 7;

    // Number of bits in one serial phase word
    localparam logic [BIT_CNT_W-1:0] WORD_BITS = 4'h6;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_MAX = 4'hF;

    // Timing: core clock period and least latch strobe spacing
    localparam int CORE_PERIOD_NS = 100;
    localparam int STROBE_SPACING_MIN_NS = 630;
    localparam int STROBE_SPACING_CYC_I =
        (STROBE_SPACING_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int SPACING_CNT_W = 4;
    localparam logic [SPACING_CNT_W-1:0] STROBE_SPACING_CYC =
        SPACING_CNT_W'(STROBE_SPACING_CYC_I);

    // Register byte offsets
    localparam logic [AXI_ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [AXI_ADDR_W-1:0] REG_FLAGS = 8'h08;
    localparam logic [AXI_ADDR_W-1:0] REG_LATCH_COUNT = 8'h0C;
    localparam logic [AXI_ADDR_W-1:0] REG_SHIFT = 8'h10;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Three pins shared between serial and parallel use
    typedef struct packed {
        logic latch_or_bit3;
        logic sclk_or_bit2;
        logic sdata_or_bit1;
    } shared_ctrl_t;

    typedef struct packed {
        logic strict_count;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = 1'h0;

    typedef struct packed {
        logic short_word;
        logic spacing_err;
    } flags_t;

    localparam flags_t FLAGS_RESET = 2'h0;

    typedef struct packed {
        logic [BIT_CNT_W-1:0] bit_count;
        logic latch_level;
        logic serial_mode;
        logic [PHASE_W-1:0] phase;
    } status_t;

endpackage

/* File: hdl/pin_filter.sv */
// Three-stage synchroniser and agreement filter for asynchronous pins
`timescale 1ns/1ps
module pin_filter #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_level
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] next_level;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            // A change counts only once stages two and three agree
            always_comb begin
                next_level[g] = (stage2[g] == stage3[g]) ? stage3[g] : level[g];
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level <= '0;
        end else begin
            stage1 <= i_async;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= next_level;
        end
    end

    assign o_level = level;

endmodule

/* File: hdl/phase_shift_control_port.sv */
// Control port of a 6-bit phase shifter: serial and direct parallel modes
//
// Contract
// - A high serial_parallel_select turns the serial control interface on.
// - A latch_strobe rising edge after six bits moves the shifted word to the phase state.
// - Serial clock edges are ignored while latch_strobe is high.
// - serial_chain_out is serial_word_in delayed by six serial clock cycles.
// - A low serial_parallel_select disables the serial control interface.
// - In serial mode the shared pins act as latch_strobe, serial clock and serial_word_in.
// - In parallel mode the shared pins act as phase_bit_3, phase_bit_2 and phase_bit_1.
// - In serial mode the phase state holds while latch_strobe stays low.
// - In parallel mode the phase state follows the six phase bit inputs.
// - A low pin level reads as 0 and a high level as 1.
// - Phase bits one to six weigh 5.6 to 180 degrees, and all zeros is the reference.
`timescale 1ns/1ps
module phase_shift_control_port (
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    input wire logic I_SERIAL_PARALLEL_SELECT,
    input wire phase_shift_pkg::shared_ctrl_t I_SHARED_CTRL,
    input wire logic [2:0] I_PHASE_BIT_HI,
    output logic [phase_shift_pkg::PHASE_W-1:0] O_PHASE_STATE,
    output logic O_SERIAL_CHAIN_OUT,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [phase_shift_pkg::AXI_ADDR_W-1:0] I_AWADDR,
    input wire logic I_WVALID,
    output logic O_WREADY,
    input wire logic [phase_shift_pkg::AXI_DATA_W-1:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    output logic O_BVALID,
    input wire logic I_BREADY,
    output logic [1:0] O_BRESP,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    input wire logic [phase_shift_pkg::AXI_ADDR_W-1:0] I_ARADDR,
    output logic O_RVALID,
    input wire logic I_RREADY,
    output logic [phase_shift_pkg::AXI_DATA_W-1:0] O_RDATA,
    output logic [1:0] O_RRESP
);
    import phase_shift_pkg::*;

    // Pin synchronisation
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_flt;
    logic sel_f;
    shared_ctrl_t shared_f;
    logic [2:0] hi_f;

    assign pins_raw = {I_SERIAL_PARALLEL_SELECT, I_SHARED_CTRL, I_PHASE_BIT_HI};

    // Pin levels taken as plain 0 and 1 after filtering
    pin_filter #(
        .WIDTH(SYNC_W)
    ) u_pin_filter (
        .i_clk(I_CORE_CLK),
        .i_nrst(I_NRST),
        .i_async(pins_raw),
        .o_level(pins_flt)
    );

    assign sel_f = pins_flt[6];
    assign shared_f = pins_flt[5:3];
    assign hi_f = pins_flt[2:0];

    // Port core state
    logic sclk_prev;
    logic latch_prev;
    logic [PHASE_W-1:0] shift;
    logic [PHASE_W-1:0] phase;
    logic [BIT_CNT_W-1:0] bit_count;
    logic [SPACING_CNT_W-1:0] spacing_cnt;
    logic [LATCH_CNT_W-1:0] latch_count;
    ctrl_t ctrl;
    flags_t flags;

    logic next_sclk_prev;
    logic next_latch_prev;
    logic [PHASE_W-1:0] next_shift;
    logic [PHASE_W-1:0] next_phase;
    logic [BIT_CNT_W-1:0] next_bit_count;
    logic [SPACING_CNT_W-1:0] next_spacing_cnt;
    logic [LATCH_CNT_W-1:0] next_latch_count;
    ctrl_t next_ctrl;
    flags_t next_flags;

    // Bus write side effects, produced by the bus logic below
    logic wr_fire;
    logic [AXI_ADDR_W-1:0] wr_addr;
    logic [AXI_DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;

    logic serial_mode;
    logic sclk_rise;
    logic latch_rise;
    logic latch_ok;
    flags_t flag_set;
    flags_t flag_clr;

    always_comb begin
        serial_mode = sel_f;
        // Shared pins carry strobe, clock and data in serial mode
        sclk_rise = shared_f.sclk_or_bit2 & ~sclk_prev;
        latch_rise = shared_f.latch_or_bit3 & ~latch_prev;
        latch_ok = !ctrl.strict_count || (bit_count >= WORD_BITS);

        next_sclk_prev = shared_f.sclk_or_bit2;
        next_latch_prev = shared_f.latch_or_bit3;
        next_shift = shift;
        next_phase = phase;
        next_bit_count = bit_count;
        next_latch_count = latch_count;
        next_spacing_cnt = (spacing_cnt != '0) ? spacing_cnt - 1'b1 : spacing_cnt;
        flag_set = FLAGS_RESET;

        if (serial_mode) begin
            // Clock edges while the strobe is high are masked
            if (sclk_rise && !shared_f.latch_or_bit3) begin
                // First bit in travels to the top, so it ends as bit six
                next_shift = {shift[PHASE_W-2:0], shared_f.sdata_or_bit1};
                if (bit_count != BIT_CNT_MAX) begin
                    next_bit_count = bit_count + 1'b1;
                end
            end
            // Phase moves only on a strobe rise, otherwise it holds
            if (latch_rise) begin
                if (latch_ok) begin
                    next_phase = shift;
                    next_latch_count = latch_count + 1'b1;
                end else begin
                    flag_set.short_word = 1'b1;
                end
                next_bit_count = '0;
                // Strobes closer than the least spacing are reported
                if (spacing_cnt != '0) begin
                    flag_set.spacing_err = 1'b1;
                end
                next_spacing_cnt = STROBE_SPACING_CYC - 1'b1;
            end
        end else begin
            // Parallel mode: pins map straight onto the phase bits
            next_phase = {hi_f, shared_f.latch_or_bit3, shared_f.sclk_or_bit2,
                shared_f.sdata_or_bit1};
            next_bit_count = '0;
        end

        next_ctrl = ctrl;
        flag_clr = FLAGS_RESET;
        if (wr_fire && wr_strb[0]) begin
            if (wr_addr == REG_CTRL) begin
                next_ctrl = wr_data[$bits(ctrl_t)-1:0];
            end
            if (wr_addr == REG_FLAGS) begin
                flag_clr = wr_data[$bits(flags_t)-1:0];
            end
        end
        // A flag set in the clearing cycle survives
        next_flags = (flags & ~flag_clr) | flag_set;
    end

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            sclk_prev <= 1'b0;
            latch_prev <= 1'b0;
            shift <= '0;
            phase <= '0;
            bit_count <= '0;
            spacing_cnt <= '0;
            latch_count <= '0;
            ctrl <= CTRL_RESET;
            flags <= FLAGS_RESET;
        end else begin
            sclk_prev <= next_sclk_prev;
            latch_prev <= next_latch_prev;
            shift <= next_shift;
            phase <= next_phase;
            bit_count <= next_bit_count;
            spacing_cnt <= next_spacing_cnt;
            latch_count <= next_latch_count;
            ctrl <= next_ctrl;
            flags <= next_flags;
        end
    end

    assign O_PHASE_STATE = phase;
    // Last stage of the six-stage shift register
    assign O_SERIAL_CHAIN_OUT = shift[PHASE_W-1];

    // AXI4-Lite write channel
    logic aw_got;
    logic w_got;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic [AXI_DATA_W-1:0] w_data;
    logic [3:0] w_strb;

    logic next_aw_got;
    logic next_w_got;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic [AXI_ADDR_W-1:0] next_aw_addr;
    logic [AXI_DATA_W-1:0] next_w_data;
    logic [3:0] next_w_strb;
    logic wr_mapped;

    assign wr_fire = aw_got && w_got && !bvalid;
    assign wr_addr = aw_addr;
    assign wr_data = w_data;
    assign wr_strb = w_strb;

    always_comb begin
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_awready = awready;
        next_wready = wready;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        wr_mapped = (aw_addr == REG_CTRL) || (aw_addr == REG_STATUS) ||
            (aw_addr == REG_FLAGS) || (aw_addr == REG_LATCH_COUNT) ||
            (aw_addr == REG_SHIFT);

        if (I_AWVALID && awready) begin
            next_aw_got = 1'b1;
            next_awready = 1'b0;
            next_aw_addr = I_AWADDR;
        end
        if (I_WVALID && wready) begin
            next_w_got = 1'b1;
            next_wready = 1'b0;
            next_w_data = I_WDATA;
            next_w_strb = I_WSTRB;
        end
        if (wr_fire) begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        if (bvalid && I_BREADY) begin
            next_bvalid = 1'b0;
            next_bresp = RESP_OKAY;
            next_awready = 1'b1;
            next_wready = 1'b1;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
        end
    end

    assign O_AWREADY = awready;
    assign O_WREADY = wready;
    assign O_BVALID = bvalid;
    assign O_BRESP = bresp;

    // AXI4-Lite read channel
    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_DATA = 1'b1
    } rd_state_t;

    rd_state_t rd_state;
    rd_state_t next_rd_state;
    logic arready;
    logic rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic next_arready;
    logic next_rvalid;
    logic [AXI_DATA_W-1:0] next_rdata;
    logic [1:0] next_rresp;
    status_t status;

    always_comb begin
        status.bit_count = bit_count;
        status.latch_level = shared_f.latch_or_bit3;
        status.serial_mode = serial_mode;
        status.phase = phase;

        next_rd_state = rd_state;
        next_arready = arready;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;

        unique case (rd_state)
            RD_IDLE: begin
                if (I_ARVALID) begin
                    next_rd_state = RD_DATA;
                    next_arready = 1'b0;
                    next_rvalid = 1'b1;
                    next_rresp = RESP_OKAY;
                    next_rdata = '0;
                    unique case (I_ARADDR)
                        REG_CTRL: next_rdata[$bits(ctrl_t)-1:0] = ctrl;
                        REG_STATUS: next_rdata[$bits(status_t)-1:0] = status;
                        REG_FLAGS: next_rdata[$bits(flags_t)-1:0] = flags;
                        REG_LATCH_COUNT: next_rdata[LATCH_CNT_W-1:0] = latch_count;
                        REG_SHIFT: next_rdata[PHASE_W-1:0] = shift;
                        default: next_rresp = RESP_SLVERR;
                    endcase
                end
            end
            RD_DATA: begin
                if (I_RREADY) begin
                    next_rd_state = RD_IDLE;
                    next_arready = 1'b1;
                    next_rvalid = 1'b0;
                    next_rdata = '0;
                    next_rresp = RESP_OKAY;
                end
            end
        endcase
    end

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rd_state <= RD_IDLE;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else begin
            rd_state <= next_rd_state;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    assign O_ARREADY = arready;
    assign O_RVALID = rvalid;
    assign O_RDATA = rdata;
    assign O_RRESP = rresp;

endmodule

/* File: sim/phase_shift_chk.sv */
// Concurrent checks on the control pins and phase outputs
`timescale 1ns/1ps
module phase_shift_chk (
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    input wire logic I_SERIAL_PARALLEL_SELECT,
    input wire phase_shift_pkg::shared_ctrl_t I_SHARED_CTRL,
    input wire logic [2:0] I_PHASE_BIT_HI,
    input wire logic [phase_shift_pkg::PHASE_W-1:0] O_PHASE_STATE,
    input wire logic O_SERIAL_CHAIN_OUT
);
    import phase_shift_pkg::*;
    logic sel;
    logic le;
    logic sck;
    logic sck_d;
    logic [PHASE_W-1:0] word;
    assign sel = I_SERIAL_PARALLEL_SELECT;
    assign le = I_SHARED_CTRL.latch_or_bit3;
    assign sck = I_SHARED_CTRL.sclk_or_bit2;
    // Pin-level copy of the six-stage shift register
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            sck_d <= 1'h0;
            word <= 6'h00;
        end else begin
            sck_d <= sck;
            if (sel && !le && sck && !sck_d) begin
                word <= {word[PHASE_W-2:0], I_SHARED_CTRL.sdata_or_bit1};
            end
        end
    end
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_NRST);
    latch_apply_a: assert property (sel && $rose(le) |-> ##[1:8] O_PHASE_STATE == word)
        else $error("phase not loaded from shifted word");
    hold_low_a: assert property ((sel && !le) [*8] |-> $stable(O_PHASE_STATE))
        else $error("phase moved while strobe low");
    hold_high_a: assert property ((sel && le) [*8] |-> $stable(O_PHASE_STATE))
        else $error("phase moved while strobe held high");
    clock_mask_a: assert property ((sel && le) [*8] |-> $stable(O_SERIAL_CHAIN_OUT))
        else $error("shift while strobe high");
    chain_tail_a: assert property ((sel && !le && $stable(sck)) [*8]
        |-> O_SERIAL_CHAIN_OUT == word[PHASE_W-1])
        else $error("chain output is not the sixth stage");
    rise_sample_a: assert property ($changed(O_SERIAL_CHAIN_OUT)
        |-> $past(sck, 3) || $past(sck, 4))
        else $error("chain moved without a clock rise");
    par_frozen_a: assert property ((!sel) [*8] |-> $stable(O_SERIAL_CHAIN_OUT))
        else $error("shift in parallel mode");
    par_follow_a: assert property ((!sel && $stable({I_PHASE_BIT_HI, I_SHARED_CTRL})) [*8]
        |-> O_PHASE_STATE == {I_PHASE_BIT_HI, I_SHARED_CTRL})
        else $error("phase does not follow parallel pins");
endmodule

/* File: sim/serial_ctrl_model.sv */
// Controller model driving the mode, shared and parallel control pins
`timescale 1ns/1ps
module serial_ctrl_model (
    input wire logic i_clk,
    output logic o_select,
    output phase_shift_pkg::shared_ctrl_t o_shared,
    output logic [2:0] o_bit_hi
);
    import phase_shift_pkg::*;
    // Half of the 800 ns link clock period in core cycles
    localparam int HALF = 4;
    initial begin
        o_select = 1'h0;
        o_shared = 3'h0;
        o_bit_hi = 3'h0;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // Shifts n bits, most significant first; strobe pin is left alone
    task automatic send_bits(input logic [15:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            o_shared.sdata_or_bit1 <= bits[i];
            wait_cyc(HALF);
            o_shared.sclk_or_bit2 <= 1'h1;
            wait_cyc(HALF);
            o_shared.sclk_or_bit2 <= 1'h0;
        end
        // Released data line shows the inverse of the last bit
        o_shared.sdata_or_bit1 <= ~bits[0];
    endtask
    task automatic set_le(input logic v);
        o_shared.latch_or_bit3 <= v;
        wait_cyc(10);
    endtask
    // Rises stay 2000 ns apart
    task automatic strobe();
        set_le(1'h1);
        set_le(1'h0);
    endtask
    // Short strobe, n cycles high then n low, to provoke a spacing fault
    task automatic pulse_le(input int n);
        o_shared.latch_or_bit3 <= 1'h1;
        wait_cyc(n);
        o_shared.latch_or_bit3 <= 1'h0;
        wait_cyc(n);
    endtask
    task automatic set_mode(input logic serial, input logic [5:0] bits);
        o_select <= serial;
        {o_bit_hi, o_shared} <= bits;
        wait_cyc(12);
    endtask
endmodule

/* File: sim/phase_shift_control_port_test.sv */
// Self-checking bench for the phase shift control port
`timescale 1ns/1ps
module phase_shift_control_port_test;
    import phase_shift_pkg::*;
    logic core_clk = 1'h0;
    logic nrst = 1'h0;
    logic sel;
    shared_ctrl_t sh;
    logic [2:0] hi;
    logic [PHASE_W-1:0] phase;
    logic chain;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic [5:0] par [4] = '{6'h15, 6'h2A, 6'h3F, 6'h38};
    int n_fail = 0;
    int total_checks = 0;
    always #50 core_clk = ~core_clk;
    phase_shift_control_port dut (.I_CORE_CLK(core_clk), .I_NRST(nrst),
        .I_SERIAL_PARALLEL_SELECT(sel), .I_SHARED_CTRL(sh), .I_PHASE_BIT_HI(hi),
        .O_PHASE_STATE(phase), .O_SERIAL_CHAIN_OUT(chain), .I_AWVALID(awvalid),
        .O_AWREADY(awready), .I_AWADDR(awaddr), .I_WVALID(wvalid), .O_WREADY(wready),
        .I_WDATA(wdata), .I_WSTRB(4'hF), .O_BVALID(bvalid), .I_BREADY(bready),
        .O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr),
        .O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp));
    serial_ctrl_model ctl (.i_clk(core_clk), .o_select(sel), .o_shared(sh), .o_bit_hi(hi));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        awvalid <= 1'h1;
        awaddr <= a;
        wvalid <= 1'h1;
        wdata <= d;
        bready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (!(bready && bvalid));
        rs = bresp;
        bready <= 1'h0;
        @(posedge core_clk);
    endtask
    task automatic axi_rd(input logic [7:0] a);
        arvalid <= 1'h1;
        araddr <= a;
        rready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'h0;
        end while (!(rready && rvalid));
        rd = rdata;
        rs = rresp;
        rready <= 1'h0;
        @(posedge core_clk);
    endtask
    task automatic finish_test();
        if (n_fail == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        nrst <= 1'h1;
        repeat (4) @(posedge core_clk);
        chk("phase_reset", 32'h0, 32'(phase));
        chk("chain_reset", 32'h0, 32'(chain));
        axi_wr(REG_CTRL, 32'h1);
        chk("ctrl_wr_resp", 32'(RESP_OKAY), 32'(rs));
        axi_rd(REG_CTRL);
        chk("ctrl_rd", 32'h1, rd);
        axi_wr(REG_CTRL, 32'h0);
        axi_wr(REG_LATCH_COUNT, 32'hFFFF);
        axi_wr(8'h40, 32'h5);
        chk("unmapped_wr_resp", 32'(RESP_SLVERR), 32'(rs));
        axi_rd(8'h40);
        chk("unmapped_rd_resp", 32'(RESP_SLVERR), 32'(rs));
        chk("unmapped_rd", 32'h0, rd);
        ctl.set_mode(1'h1, 6'h00);
        ctl.send_bits(16'h002D, 6);
        ctl.wait_cyc(10);
        chk("phase_unlatched", 32'h0, 32'(phase));
        chk("chain_six", 32'h1, 32'(chain));
        ctl.strobe();
        chk("phase_six", 32'h2D, 32'(phase));
        // Eight bits shifted: the first two fall out of the register
        ctl.send_bits(16'h0087, 8);
        ctl.strobe();
        chk("phase_eight", 32'h07, 32'(phase));
        chk("chain_eight", 32'h0, 32'(chain));
        ctl.set_le(1'h1);
        ctl.send_bits(16'h0038, 6);
        ctl.set_le(1'h0);
        ctl.strobe();
        chk("phase_masked", 32'h07, 32'(phase));
        chk("chain_masked", 32'h0, 32'(chain));
        axi_rd(REG_STATUS);
        chk("status", 32'h47, rd);
        axi_rd(REG_LATCH_COUNT);
        chk("latch_count", 32'h4, rd);
        axi_rd(REG_FLAGS);
        chk("flags", 32'h0, rd);
        axi_wr(REG_CTRL, 32'h1);
        ctl.send_bits(16'h0019, 6);
        // Two rises four cycles apart: the first applies, the second finds no bits
        ctl.pulse_le(2);
        ctl.pulse_le(2);
        ctl.wait_cyc(10);
        chk("phase_strict", 32'h19, 32'(phase));
        axi_rd(REG_FLAGS);
        chk("flags_close", 32'h3, rd);
        axi_rd(REG_LATCH_COUNT);
        chk("latch_strict", 32'h5, rd);
        axi_wr(REG_FLAGS, 32'h3);
        axi_wr(REG_CTRL, 32'h0);
        axi_rd(REG_FLAGS);
        chk("flags_clear", 32'h0, rd);
        foreach (par[i]) begin
            ctl.set_mode(1'h0, par[i]);
            chk("phase_parallel", 32'(par[i]), 32'(phase));
            chk("chain_parallel", 32'h0, 32'(chain));
        end
        ctl.set_mode(1'h1, 6'h38);
        chk("phase_hold", 32'h38, 32'(phase));
        ctl.strobe();
        chk("phase_frozen_word", 32'h19, 32'(phase));
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        $display("[ERR] watchdog expected done seen hang");
        finish_test();
    end
endmodule
bind phase_shift_control_port phase_shift_chk watch (.I_CORE_CLK(I_CORE_CLK),
    .I_NRST(I_NRST), .I_SERIAL_PARALLEL_SELECT(I_SERIAL_PARALLEL_SELECT),
    .I_SHARED_CTRL(I_SHARED_CTRL), .I_PHASE_BIT_HI(I_PHASE_BIT_HI),
    .O_PHASE_STATE(O_PHASE_STATE), .O_SERIAL_CHAIN_OUT(O_SERIAL_CHAIN_OUT));
